// ===== hw/pcnt_pkg.sv
// Package for the presettable 4-bit counter block.
// Holds register offsets, field positions, reset values and widths shared by every module except the carry decoder.
// Assumes an APB master with 32-bit data and byte addressing.

`default_nettype none

package pcnt_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int unsigned PCNT_CNT_W  = 4;
	localparam int unsigned PCNT_ADDR_W = 12;
	localparam int unsigned PCNT_DATA_W = 32;
	localparam int unsigned PCNT_WRAP_W = 8;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [PCNT_ADDR_W-1:0] PCNT_OFS_CTRL   = 12'h000;
	localparam logic [PCNT_ADDR_W-1:0] PCNT_OFS_CMD    = 12'h004;
	localparam logic [PCNT_ADDR_W-1:0] PCNT_OFS_PRESET = 12'h008;
	localparam logic [PCNT_ADDR_W-1:0] PCNT_OFS_STATUS = 12'h00C;
	localparam logic [PCNT_ADDR_W-1:0] PCNT_OFS_WRAPS  = 12'h010;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	// CTRL
	localparam int unsigned PCNT_CTRL_SRC_SEL    = 0;
	localparam int unsigned PCNT_CTRL_CNT_GATE   = 1;
	localparam int unsigned PCNT_CTRL_CARRY_GATE = 2;
	localparam int unsigned PCNT_CTRL_W          = 3;
	// CMD (write-only strobes)
	localparam int unsigned PCNT_CMD_CLEAR = 0;
	localparam int unsigned PCNT_CMD_LOAD  = 1;
	// STATUS
	localparam int unsigned PCNT_ST_COUNT_LSB = 0;
	localparam int unsigned PCNT_ST_CARRY     = 4;
	localparam int unsigned PCNT_ST_CLEAR_N   = 5;
	localparam int unsigned PCNT_ST_LOAD_N    = 6;
	localparam int unsigned PCNT_ST_ASYNC     = 7;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [PCNT_CTRL_W-1:0] PCNT_CTRL_RST   = 3'h0;
	localparam logic [PCNT_CNT_W-1:0]  PCNT_PRESET_RST = 4'h0;
	localparam logic [PCNT_CNT_W-1:0]  PCNT_STATE_RST  = 4'h0;
	localparam logic [PCNT_WRAP_W-1:0] PCNT_WRAPS_RST  = 8'h00;
	localparam logic [PCNT_DATA_W-1:0] PCNT_RDATA_ZERO = 32'h0000_0000;

endpackage : pcnt_pkg

`default_nettype wire

// ===== hw/pcnt_carry.sv
// Terminal-count decoder for one counter stage.
// Assumes the state comes from flops; output is purely combinational.

`timescale 1ns/1ps
`default_nettype none

module pcnt_carry #(
	parameter int unsigned W = 4
) (
	// Stage state and gate
	input  wire logic [W-1:0] state,
	input  wire logic         carry_gate,
	// Look-ahead carry
	output logic              carry_out
);

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	// High only at all ones with the carry gate high; load and count gate play no part
	assign carry_out = carry_gate & (&state);

endmodule : pcnt_carry

`default_nettype wire

// ===== hw/pcnt_core.sv
// Counter core: 4-bit presettable binary up-counter with selectable clear style.
// Assumes all control inputs are synchronous to clk; clear_n may be asynchronous
// when ASYNC_CLEAR is set.

`timescale 1ns/1ps
`default_nettype none

module pcnt_core
	import pcnt_pkg::*;
#(
	parameter int unsigned W           = PCNT_CNT_W,
	parameter bit          ASYNC_CLEAR = 1'b1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Controls
	input  wire logic         clear_n,
	input  wire logic         soft_clear,
	input  wire logic         load_n,
	input  wire logic [W-1:0] preset,
	input  wire logic         count_gate,
	input  wire logic         carry_gate,
	// State
	output logic [W-1:0]      state,
	output logic              wrap
);

	logic [W-1:0] state_q;
	logic [W-1:0] state_d;
	logic         cnt_en;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// Load blocks counting whatever the gates do; count needs all three high
	assign cnt_en = count_gate & carry_gate & load_n;

	// Load beats count, and no control leaves the state alone
	always_comb begin
		if (!load_n) begin
			state_d = preset;
		end else if (cnt_en) begin
			state_d = W'(state_q + 1'b1);
		end else begin
			state_d = state_q;
		end
	end

	// Wrap event marks the all-ones to zero step
	assign wrap = cnt_en & (&state_q);

	// ------------------------------------------------------------
	// State flops
	// ------------------------------------------------------------
	generate
		if (ASYNC_CLEAR) begin : g_async
			logic arst_n;
			// Clear pin joins the reset net; it must be glitch free upstream
			assign arst_n = rst_n & clear_n;
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					state_q <= PCNT_STATE_RST;
				end else if (soft_clear) begin
					state_q <= PCNT_STATE_RST;
				end else begin
					state_q <= state_d;
				end
			end
		end else begin : g_sync
			// Clear sampled at the edge, so decoded moduli stay glitch free
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					state_q <= PCNT_STATE_RST;
				end else if (!clear_n || soft_clear) begin
					state_q <= PCNT_STATE_RST;
				end else begin
					state_q <= state_d;
				end
			end
		end
	endgenerate

	assign state = state_q;

endmodule : pcnt_core

`default_nettype wire

// ===== hw/pcnt_top.sv
// Top of the presettable counter block: counter pins plus an APB register slave.
// Assumes an APB master on pclk; counter pins are synchronous to pclk.

`timescale 1ns/1ps
`default_nettype none

module pcnt_top
	import pcnt_pkg::*;
#(
	parameter bit ASYNC_CLEAR = 1'b1
) (
	// Clock and reset
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	// APB slave
	input  wire logic [pcnt_pkg::PCNT_ADDR_W-1:0] paddr,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [pcnt_pkg::PCNT_DATA_W-1:0] pwdata,
	output logic                                 pready,
	output logic [pcnt_pkg::PCNT_DATA_W-1:0]      prdata,
	output logic                                 pslverr,
	// Counter pins
	input  wire logic [pcnt_pkg::PCNT_CNT_W-1:0]  preset_in,
	input  wire logic                            load_n,
	input  wire logic                            clear_n,
	input  wire logic                            count_gate,
	input  wire logic                            carry_gate,
	output logic [pcnt_pkg::PCNT_CNT_W-1:0]       count_out,
	output logic                                 carry_out
);

	import pcnt_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [PCNT_CTRL_W-1:0] ctrl_q;
	logic [PCNT_CNT_W-1:0]  preset_q;
	logic [PCNT_WRAP_W-1:0] wraps_q;
	logic [PCNT_DATA_W-1:0] prdata_q;
	logic                   soft_clear_q;
	logic                   soft_load_q;
	logic                   setup_ph;
	logic                   wr_acc;
	logic                   rd_setup;
	logic                   addr_hit;
	logic                   eff_load_n;
	logic [PCNT_CNT_W-1:0]  eff_preset;
	logic                   eff_cnt_gate;
	logic                   eff_carry_gate;
	logic [PCNT_CNT_W-1:0]  state;
	logic                   wrap;
	logic                   carry;

	// Address decode shared by write and error paths
	function automatic logic pcnt_mapped(input logic [PCNT_ADDR_W-1:0] a);
		return (a == PCNT_OFS_CTRL) || (a == PCNT_OFS_CMD) || (a == PCNT_OFS_PRESET)
			|| (a == PCNT_OFS_STATUS) || (a == PCNT_OFS_WRAPS);
	endfunction : pcnt_mapped

	// ------------------------------------------------------------
	// APB phases
	// ------------------------------------------------------------
	// Zero wait states: read data is captured in the setup cycle
	assign setup_ph = psel & ~penable;
	assign rd_setup = setup_ph & ~pwrite;
	assign addr_hit = pcnt_mapped(paddr);
	assign wr_acc   = psel & penable & pwrite & addr_hit;
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~addr_hit;   // Unmapped address answers with an error

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	// Source select, software count gate and software carry gate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= PCNT_CTRL_RST;
		end else if (wr_acc && paddr == PCNT_OFS_CTRL) begin
			ctrl_q <= pwdata[PCNT_CTRL_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// Preset register
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			preset_q <= PCNT_PRESET_RST;
		end else if (wr_acc && paddr == PCNT_OFS_PRESET) begin
			preset_q <= pwdata[PCNT_CNT_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// Command strobes
	// ------------------------------------------------------------
	// One-cycle pulses; they act at the edge after the write completes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			soft_clear_q <= 1'b0;
			soft_load_q  <= 1'b0;
		end else begin
			soft_clear_q <= wr_acc && paddr == PCNT_OFS_CMD && pwdata[PCNT_CMD_CLEAR];
			soft_load_q  <= wr_acc && paddr == PCNT_OFS_CMD && pwdata[PCNT_CMD_LOAD];
		end
	end

	// ------------------------------------------------------------
	// Control source selection
	// ------------------------------------------------------------
	// Pin load always counts; a software load picks the preset register instead
	assign eff_load_n     = load_n & ~soft_load_q;
	assign eff_preset     = (!load_n) ? preset_in : preset_q;
	assign eff_cnt_gate   = ctrl_q[PCNT_CTRL_SRC_SEL] ? ctrl_q[PCNT_CTRL_CNT_GATE] : count_gate;
	assign eff_carry_gate = ctrl_q[PCNT_CTRL_SRC_SEL] ? ctrl_q[PCNT_CTRL_CARRY_GATE] : carry_gate;

	// ------------------------------------------------------------
	// Counter stage and carry decode
	// ------------------------------------------------------------
	pcnt_core #(
		.W           (PCNT_CNT_W),
		.ASYNC_CLEAR (ASYNC_CLEAR)
	) u_core (
		.clk        (pclk),
		.rst_n      (presetn),
		.clear_n    (clear_n),
		.soft_clear (soft_clear_q),
		.load_n     (eff_load_n),
		.preset     (eff_preset),
		.count_gate (eff_cnt_gate),
		.carry_gate (eff_carry_gate),
		.state      (state),
		.wrap       (wrap)
	);

	pcnt_carry #(
		.W (PCNT_CNT_W)
	) u_carry (
		.state      (state),
		.carry_gate (eff_carry_gate),
		.carry_out  (carry)
	);

	// Outputs are the state flops and the carry decode directly, so a
	// downstream stage sees the carry in the same cycle for cascading
	assign count_out = state;
	assign carry_out = carry;

	// ------------------------------------------------------------
	// Wrap counter
	// ------------------------------------------------------------
	// Counts all-ones to zero steps; saturates instead of rolling over,
	// and a wrap in the cycle of a clear write restarts the count at one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wraps_q <= PCNT_WRAPS_RST;
		end else if (wrap) begin
			if (wr_acc && paddr == PCNT_OFS_WRAPS) begin
				wraps_q <= PCNT_WRAP_W'(1);
			end else if (~&wraps_q) begin
				wraps_q <= PCNT_WRAP_W'(wraps_q + 1'b1);
			end
		end else if (wr_acc && paddr == PCNT_OFS_WRAPS) begin
			wraps_q <= PCNT_WRAPS_RST;
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	// Captured at the setup edge and held through the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= PCNT_RDATA_ZERO;
		end else if (rd_setup) begin
			prdata_q <= PCNT_RDATA_ZERO;
			unique case (1'b1)
				paddr == PCNT_OFS_CTRL: begin
					prdata_q[PCNT_CTRL_W-1:0] <= ctrl_q;
				end
				paddr == PCNT_OFS_PRESET: begin
					prdata_q[PCNT_CNT_W-1:0] <= preset_q;
				end
				paddr == PCNT_OFS_STATUS: begin
					prdata_q[PCNT_ST_COUNT_LSB +: PCNT_CNT_W] <= state;
					prdata_q[PCNT_ST_CARRY]                   <= carry;
					prdata_q[PCNT_ST_CLEAR_N]                 <= clear_n;
					prdata_q[PCNT_ST_LOAD_N]                  <= load_n;
					prdata_q[PCNT_ST_ASYNC]                   <= ASYNC_CLEAR;
				end
				paddr == PCNT_OFS_WRAPS: begin
					prdata_q[PCNT_WRAP_W-1:0] <= wraps_q;
				end
				default: begin
					prdata_q <= PCNT_RDATA_ZERO;   // CMD and unmapped read as zero
				end
			endcase
		end
	end

	assign prdata = prdata_q;

endmodule : pcnt_top

`default_nettype wire

// ===== verif/pcnt_chk.sv
// Checker for the counter top: pin and APB relations.
// Assumes it is bound into pcnt_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pcnt_chk
	import pcnt_pkg::*;
(
	// Clock, reset and APB
	input wire logic                              pclk,
	input wire logic                              presetn,
	input wire logic [pcnt_pkg::PCNT_ADDR_W-1:0] paddr,
	input wire logic                              psel,
	input wire logic                              penable,
	input wire logic                              pwrite,
	input wire logic [pcnt_pkg::PCNT_DATA_W-1:0] pwdata,
	input wire logic                              pready,
	input wire logic                              pslverr,
	// Counter pins
	input wire logic [pcnt_pkg::PCNT_CNT_W-1:0]  preset_in,
	input wire logic                              load_n,
	input wire logic                              clear_n,
	input wire logic                              count_gate,
	input wire logic                              carry_gate,
	input wire logic [pcnt_pkg::PCNT_CNT_W-1:0]  count_out,
	input wire logic                              carry_out
);
	// ----
	// Counter and APB relations
	// ----
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Unmapped: past the last register or not word aligned
	logic bad_addr;
	assign bad_addr = (paddr > PCNT_OFS_WRAPS) || (paddr[1:0] != 2'h0);
	// Mirror of the register path: software gates and command strobes move the
	// state too, so the pin relations must know when software is in charge
	logic [PCNT_CTRL_W-1:0] ctrl_m;
	logic                   soft_q;
	logic                   cg;
	logic                   tg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_m <= PCNT_CTRL_RST;
			soft_q <= 1'b0;
		end else begin
			if (psel && penable && pwrite && paddr == PCNT_OFS_CTRL) begin
				ctrl_m <= pwdata[PCNT_CTRL_W-1:0];
			end
			soft_q <= psel && penable && pwrite && paddr == PCNT_OFS_CMD
				&& (pwdata[PCNT_CMD_CLEAR] || pwdata[PCNT_CMD_LOAD]);
		end
	end
	// Effective gates as the counter sees them
	assign cg = ctrl_m[PCNT_CTRL_SRC_SEL] ? ctrl_m[PCNT_CTRL_CNT_GATE] : count_gate;
	assign tg = ctrl_m[PCNT_CTRL_SRC_SEL] ? ctrl_m[PCNT_CTRL_CARRY_GATE] : carry_gate;
	chk_carry_decode: assert property (carry_out == (&count_out && tg))
		else $error("carry out does not follow state and carry gate");
	chk_load_copy: assert property (clear_n && !load_n && !soft_q |=> count_out == $past(preset_in))
		else $error("load did not copy preset");
	chk_count_step: assert property (clear_n && load_n && cg && tg && !soft_q |=>
		count_out == $past(count_out) + 4'h1) else $error("count did not advance by one");
	chk_hold_gate: assert property (clear_n && load_n && !(cg && tg) && !soft_q |=>
		$stable(count_out)) else $error("state moved with a gate low");
	chk_sync_clear: assert property (!clear_n |=> count_out == 4'h0)
		else $error("clear did not zero the state");
	chk_reset_zero: assert property ($rose(presetn) |-> count_out == 4'h0 && !carry_out)
		else $error("state not zero after reset");
	chk_apb_ready: assert property (psel && penable |-> pready)
		else $error("access phase without ready");
	chk_unmapped_err: assert property (psel && penable && bad_addr |-> pslverr)
		else $error("unmapped access without error");
	chk_mapped_ok: assert property (psel && penable && !bad_addr |-> !pslverr)
		else $error("error on mapped access");
	// Main scenarios reached
	cov_wrap: cover property (count_out == 4'hF && count_gate && carry_gate && load_n && clear_n);
	cov_load: cover property (!load_n && clear_n);
	cov_clear: cover property (!clear_n && count_out != 4'h0);
	cov_unmapped: cover property (psel && penable && bad_addr);
endmodule : pcnt_chk

bind pcnt_top pcnt_chk u_pcnt_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.pwrite(pwrite), .pwdata(pwdata),
	.penable(penable), .pready(pready), .pslverr(pslverr), .preset_in(preset_in), .load_n(load_n),
	.clear_n(clear_n), .count_gate(count_gate), .carry_gate(carry_gate), .count_out(count_out),
	.carry_out(carry_out));
`default_nettype wire

// ===== verif/pcnt_far.sv
// Far side model: an upper cascaded stage and a modulus decoder.
// Assumes the same clock and reset as the counter it watches.
`timescale 1ns/1ps
`default_nettype none
module pcnt_far
	import pcnt_pkg::*;
(
	// Clock and reset
	input wire logic                             pclk,
	input wire logic                             presetn,
	// Lower stage
	input wire logic [pcnt_pkg::PCNT_CNT_W-1:0] count_out,
	input wire logic                             carry_out,
	input wire logic                             count_gate,
	input wire logic                             load_n,
	// Modulus decode
	input wire logic                             mod_en,
	input wire logic [pcnt_pkg::PCNT_CNT_W-1:0] mod_last,
	output logic                                 mod_clear_n,
	// Upper stage
	output logic [pcnt_pkg::PCNT_CNT_W-1:0]     hi_q
);
	// Upper nibble advances only when the lower carry enables it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_q <= 4'h0;
		end else if (carry_out && count_gate && load_n) begin
			hi_q <= hi_q + 4'h1;
		end
	end
	// Glitch-free modulus: decode feeds the edge-sampled clear
	assign mod_clear_n = !(mod_en && count_out == mod_last);
endmodule : pcnt_far
`default_nettype wire

// ===== verif/tb_pcnt_top.sv
// Self-checking bench for the counter top, synchronous clear variant.
// Assumes pcnt_far as far side and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_pcnt_top;
	import pcnt_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        load_n = 1'b1, tb_clear_n = 1'b1, count_gate = 1'b0, carry_gate = 1'b0;
	logic        carry_out, mod_en = 1'b0, mod_clear_n, sw_on = 1'b0;
	logic [3:0]  preset_in = 4'h0, count_out, mod_last = 4'h0, hi_q, st = 4'h0;
	int          n_mismatch = 0, n_compared = 0;
	wire logic   clear_n = tb_clear_n && mod_clear_n;
	// Clock, 5 ns period
	always #2.5 pclk = ~pclk;
	pcnt_top #(.ASYNC_CLEAR(1'b0)) u_pcnt_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .preset_in(preset_in), .load_n(load_n),
		.clear_n(clear_n), .count_gate(count_gate), .carry_gate(carry_gate),
		.count_out(count_out), .carry_out(carry_out));
	pcnt_far u_pcnt_far (.pclk(pclk), .presetn(presetn), .count_out(count_out),
		.carry_out(carry_out), .count_gate(count_gate), .load_n(load_n), .mod_en(mod_en),
		.mod_last(mod_last), .mod_clear_n(mod_clear_n), .hi_q(hi_q));
	// ----
	// Shared tasks
	// ----
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// One cycle of pins; checks the state left by earlier edges
	task step(input logic cl, input logic ld, input logic [3:0] p, input logic g, input logic c);
		tb_clear_n <= cl;
		load_n <= ld;
		preset_in <= p;
		count_gate <= g;
		carry_gate <= c;
		@(negedge pclk);
		cmp({28'h0, count_out}, {28'h0, st});
		cmp({31'h0, carry_out}, {31'h0, &st && (c || sw_on)});
		if (!cl || (mod_en && st == mod_last))
			st = 4'h0;
		else if (!ld)
			st = p;
		else if ((g && c) || sw_on)
			st = st + 4'h1;
		@(posedge pclk);
	endtask : step
	// Setup then access; waits for ready, bounded
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [31:0] exp,
		input logic err);
		int i;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		cmp({31'h0, pready}, 32'h1);
		if (!wr) cmp(prdata, exp);
		cmp({31'h0, pslverr}, {31'h0, err});
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// ----
	// Scenarios
	// ----
	task t_walk;
		int i;
		step(1'b0, 1'b1, 4'hC, 1'b1, 1'b1);
		step(1'b1, 1'b0, 4'hC, 1'b1, 1'b1);
		for (i = 0; i < 6; i++) step(1'b1, 1'b1, 4'h0, 1'b1, 1'b1);
		step(1'b1, 1'b1, 4'h0, 1'b0, 1'b0);
		step(1'b1, 1'b1, 4'h0, 1'b0, 1'b0);
		$display("test walk done");
	endtask : t_walk
	task t_gates;
		step(1'b1, 1'b0, 4'hF, 1'b0, 1'b0);
		step(1'b1, 1'b1, 4'h0, 1'b0, 1'b1);
		step(1'b1, 1'b1, 4'h0, 1'b1, 1'b0);
		step(1'b1, 1'b0, 4'h1, 1'b0, 1'b1);
		step(1'b1, 1'b0, 4'h8, 1'b1, 1'b1);
		step(1'b0, 1'b0, 4'h5, 1'b1, 1'b1);
		step(1'b1, 1'b1, 4'h0, 1'b0, 1'b0);
		$display("test gates done");
	endtask : t_gates
	task t_cascade;
		step(1'b1, 1'b0, 4'hF, 1'b1, 1'b1);
		step(1'b1, 1'b1, 4'h0, 1'b1, 1'b1);
		step(1'b1, 1'b1, 4'h0, 1'b0, 1'b0);
		cmp({28'h0, hi_q}, 32'h2);
		$display("test cascade done");
	endtask : t_cascade
	task t_modulus;
		int i;
		mod_last <= 4'h4;
		mod_en <= 1'b1;
		step(1'b1, 1'b0, 4'h0, 1'b0, 1'b0);
		for (i = 0; i < 7; i++) step(1'b1, 1'b1, 4'h0, 1'b1, 1'b1);
		mod_en <= 1'b0;
		step(1'b1, 1'b1, 4'h0, 1'b0, 1'b0);
		$display("test modulus done");
	endtask : t_modulus
	task t_regs;
		apb(1'b1, PCNT_OFS_CTRL, 32'h6, 32'h0, 1'b0);
		apb(1'b0, PCNT_OFS_CTRL, 32'h0, 32'h6, 1'b0);
		apb(1'b1, PCNT_OFS_PRESET, 32'h9, 32'h0, 1'b0);
		apb(1'b0, PCNT_OFS_PRESET, 32'h0, 32'h9, 1'b0);
		apb(1'b0, PCNT_OFS_STATUS, 32'h0, {24'h0, 4'h6, st}, 1'b0);
		apb(1'b0, 12'h100, 32'h0, 32'h0, 1'b1);
		apb(1'b0, PCNT_OFS_CMD, 32'h0, 32'h0, 1'b0);
		apb(1'b0, PCNT_OFS_WRAPS, 32'h0, 32'h2, 1'b0);
		apb(1'b1, PCNT_OFS_WRAPS, 32'h0, 32'h0, 1'b0);
		apb(1'b0, PCNT_OFS_WRAPS, 32'h0, 32'h0, 1'b0);
		$display("test regs done");
	endtask : t_regs
	// Command strobes and software gates; software gates are both set here
	task t_soft;
		int i;
		apb(1'b1, PCNT_OFS_CMD, 32'h3, 32'h0, 1'b0);
		st = 4'h0;
		step(1'b1, 1'b1, 4'h0, 1'b0, 1'b0);
		apb(1'b1, PCNT_OFS_CMD, 32'h2, 32'h0, 1'b0);
		st = 4'h9;
		step(1'b1, 1'b1, 4'h0, 1'b0, 1'b0);
		apb(1'b1, PCNT_OFS_CTRL, 32'h7, 32'h0, 1'b0);
		st = 4'hA;
		sw_on = 1'b1;
		for (i = 0; i < 6; i++) step(1'b1, 1'b1, 4'h0, 1'b0, 1'b0);
		apb(1'b1, PCNT_OFS_CTRL, 32'h0, 32'h0, 1'b0);
		st = st + 4'h2;
		sw_on = 1'b0;
		step(1'b1, 1'b1, 4'h0, 1'b0, 1'b0);
		apb(1'b0, PCNT_OFS_WRAPS, 32'h0, 32'h1, 1'b0);
		$display("test soft done");
	endtask : t_soft
	// ----
	// Run control
	// ----
	task final_report;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report
	// Main sequence after 12 cycles of reset
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_walk();
		t_gates();
		t_cascade();
		t_modulus();
		t_regs();
		t_soft();
		final_report();
	end
	// Watchdog: tests need about 100 cycles, allow many times that
	initial begin
		#20000;
		n_mismatch++;
		final_report();
	end
endmodule : tb_pcnt_top
`default_nettype wire
